/* File: hw/wdrs_pkg.sv */
package wdrs_pkg;
    typedef struct packed {
        logic halt;
        logic stop;
        logic cpu_fast;
        logic settled;
        logic slow_tick;
        logic fast_tick;
    } wdrs_env_s;

    typedef enum logic [1:0] {
        WDRS_RUN,
        WDRS_SLEEP,
        WDRS_SETTLE,
        WDRS_OFF
    } wdrs_state_e;
endpackage

/* File: hw/wdrs_regs.svh */
`ifndef WDRS_REGS_SVH
`define WDRS_REGS_SVH

// Register byte addresses
`define WDRS_ADDR_MODE      4'h0
`define WDRS_ADDR_KEY       4'h4
`define WDRS_ADDR_STAT      4'h8
`define WDRS_ADDR_CTRL      4'hC
// Reset and key values
`define WDRS_MODE_RESET     8'h67
`define WDRS_MODE_FIXED     3'h3
`define WDRS_KEY_READ       8'h9A
`define WDRS_KEY_CLEAR      8'hAC
// Mode-register fields
`define WDRS_STOP_BIT       4
`define WDRS_FAST_BIT       3
`define WDRS_PER_MSB        2
// Period base exponents
`define WDRS_SLOW_BASE      5'h0B
`define WDRS_FAST_BASE      5'h0D
// AXI responses
`define WDRS_RESP_OKAY      2'h0
`define WDRS_RESP_SLVERR    2'h2

`endif

/* File: hw/wdrs_sync.sv */
`timescale 1ns/10ps
// Three-stage input synchroniser; a change counts when stages two and three agree
module wdrs_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Data
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] s1, s2, s3;
    logic [WIDTH-1:0] next_dout;

    always_comb begin
        next_dout = dout;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2[i] == s3[i]) begin
                next_dout[i] = s3[i];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1   <= '0;
            s2   <= '0;
            s3   <= '0;
            dout <= '0;
        end else begin
            s1   <= din;
            s2   <= s1;
            s3   <= s2;
            dout <= next_dout;
        end
    end
endmodule // wdrs_sync

/* File: hw/wdrs_top.sv */
// Contract
// - Non-stoppable: counter always on slow clock
// - Reset: count at once, slow, longest period
// - Non-stoppable: counter can never be halted
// - Non-stoppable: clock-select writes are ignored
// - Mode write clears the counter
// - Key 0xAC clears counter; software refreshes
// - Non-stoppable: runs in stop, may reset
// - Stoppable: select slow, fast or stopped
// - Stopped watchdog: misuse raises no reset
// - Stoppable: pause in halt/stop, keep count
// - Fast/fast: hold until settling elapses
// - Slow CPU, fast dog: settle or switch
// - Slow dog: resume right at stop release
// - Stoppable: halt pauses every clock combination
// - Overflow raises internal reset
// - Second mode write raises reset
// - Wrong key raises reset
// - Key register always reads 0x9A
`timescale 1ns/10ps
`include "wdrs_regs.svh"
module wdrs_top
    import wdrs_pkg::*;
#(
    parameter bit STOPPABLE = 1'b0,
    parameter int CNT_W     = 21
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address and data
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Asynchronous environment inputs
    input  wire logic        slow_tick_in,
    input  wire logic        fast_tick_in,
    input  wire logic        halt_in,
    input  wire logic        stop_in,
    input  wire logic        cpu_fast_in,
    input  wire logic        settled_in,
    // Internal reset request
    output logic             wdt_reset
);
    // Status word holds the count and four flag bits within 32
    if (CNT_W < 21 || CNT_W > 28) begin : g_bad_cnt_w
        $error("wdrs_top: CNT_W must be 21..28");
    end

    wdrs_env_s   env;
    logic [5:0]  env_raw;
    logic [5:0]  env_sync;
    logic        slow_prev, fast_prev;
    logic        slow_edge, fast_edge;

    assign env_raw = {halt_in, stop_in, cpu_fast_in, settled_in,
                      slow_tick_in, fast_tick_in};

    wdrs_sync #(.WIDTH(6)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (env_raw),
        .dout    (env_sync)
    );
    assign env = env_sync;
    assign slow_edge = env.slow_tick & ~slow_prev;
    assign fast_edge = env.fast_tick & ~fast_prev;

    // Overflow bit position from clock and period field
    function automatic logic [4:0] ovf_bit(input logic fast,
                                           input logic [2:0] per);
        ovf_bit = (fast ? `WDRS_FAST_BASE : `WDRS_SLOW_BASE) + {2'h0, per};
    endfunction

    // Register and control state
    logic [7:0]        mode_reg, next_mode_reg;
    logic              mode_written, next_mode_written;
    logic [CNT_W-1:0]  count, next_count;
    wdrs_state_e       state, next_state;
    logic              pending, next_pending;
    logic              next_wdt_reset;
    logic              was_stop, next_was_stop;
    logic              cpu_fast_seen;

    // Bus state
    logic              aw_held, next_aw_held, w_held, next_w_held;
    logic [3:0]        aw_addr, next_aw_addr;
    logic [31:0]       w_data, next_w_data;
    logic [3:0]        w_strb, next_w_strb;
    logic              next_awready, next_wready, next_bvalid;
    logic [1:0]        next_bresp;
    logic              next_arready, next_rvalid;
    logic [31:0]       next_rdata;
    logic [1:0]        next_rresp;

    logic              do_write, full_byte, fast_sel, off_sel, tick;
    logic              violation;
    logic [4:0]        obit;

    assign do_write  = aw_held && w_held && !s_axi_bvalid;
    assign full_byte = w_strb[0];
    assign fast_sel  = STOPPABLE && mode_reg[`WDRS_FAST_BIT];
    assign off_sel   = STOPPABLE && mode_reg[`WDRS_STOP_BIT];
    assign tick      = fast_sel ? fast_edge : slow_edge;
    assign obit      = ovf_bit(fast_sel, mode_reg[`WDRS_PER_MSB:0]);

    // Bus channels
    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held  = w_held;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_awready = 1'b0;
        next_wready  = 1'b0;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_arready = 1'b0;
        next_rvalid  = s_axi_rvalid;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end else if (!aw_held && s_axi_awvalid && !s_axi_bvalid) begin
            next_awready = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end else if (!w_held && s_axi_wvalid && !s_axi_bvalid) begin
            next_wready = 1'b1;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = (aw_addr == `WDRS_ADDR_MODE ||
                            aw_addr == `WDRS_ADDR_KEY ||
                            aw_addr == `WDRS_ADDR_CTRL) ?
                           `WDRS_RESP_OKAY : `WDRS_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = `WDRS_RESP_OKAY;
            case (s_axi_araddr)
                `WDRS_ADDR_MODE: next_rdata = {24'h0, mode_reg};
                `WDRS_ADDR_KEY:  next_rdata = {24'h0, `WDRS_KEY_READ};
                `WDRS_ADDR_STAT: next_rdata = {{(32-CNT_W-4){1'b0}},
                                               count, state, mode_written,
                                               pending};
                `WDRS_ADDR_CTRL: next_rdata = 32'h0;
                default: begin
                    next_rdata = 32'h0;
                    next_rresp = `WDRS_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end else if (!s_axi_rvalid && s_axi_arvalid) begin
            next_arready = 1'b1;
        end
    end

    // Watchdog core
    always_comb begin
        next_mode_reg     = mode_reg;
        next_mode_written = mode_written;
        next_count        = count;
        next_state        = state;
        next_pending      = pending;
        next_was_stop     = was_stop;
        next_wdt_reset    = 1'b0;
        violation         = 1'b0;
        if (do_write && aw_addr == `WDRS_ADDR_MODE) begin
            if (mode_written || !full_byte) begin
                violation = 1'b1;
            end else begin
                // byte write of period and fixed bits
                next_mode_reg = {`WDRS_MODE_FIXED,
                                 w_data[`WDRS_STOP_BIT:0]};
                if (!STOPPABLE) begin
                    next_mode_reg[`WDRS_STOP_BIT:`WDRS_FAST_BIT] = 2'h0;
                end
                next_mode_written = 1'b1;
                next_count = '0;
            end
        end
        if (do_write && aw_addr == `WDRS_ADDR_KEY) begin
            // key check, partial write counts as misuse
            if (full_byte && w_data[7:0] == `WDRS_KEY_CLEAR) begin
                next_count = '0;
            end else begin
                violation = 1'b1;
            end
        end
        case (state)
            WDRS_RUN: begin
                if (STOPPABLE && (env.halt || env.stop)) begin
                    next_state    = WDRS_SLEEP;
                    next_was_stop = env.stop;
                end else if (tick) begin
                    next_count = next_count + 1'b1;
                end
            end
            WDRS_SLEEP: begin
                if (!env.halt && !env.stop) begin
                    if (was_stop && fast_sel &&
                        !(env.settled || env.cpu_fast && !cpu_fast_seen)) begin
                        next_state = WDRS_SETTLE;
                    end else begin
                        next_state = WDRS_RUN;
                    end
                end
            end
            WDRS_SETTLE: begin
                // earlier of settle or CPU switch
                if (env.settled || (env.cpu_fast && !cpu_fast_seen)) begin
                    next_state = WDRS_RUN;
                end
            end
            WDRS_OFF: begin
                next_state = WDRS_OFF;
            end
            default: begin
                next_state = WDRS_RUN;
            end
        endcase
        // stopped dog stays off, no reset
        if (off_sel || next_mode_reg[`WDRS_STOP_BIT] && STOPPABLE) begin
            next_state = WDRS_OFF;
            violation  = 1'b0;
        end
        if (violation && state != WDRS_RUN) begin
            // Misuse while clock halted fires when counting resumes
            next_pending = 1'b1;
        end else if (violation) begin
            next_wdt_reset = 1'b1;
        end
        if (state == WDRS_RUN && pending) begin
            next_pending   = 1'b0;
            next_wdt_reset = 1'b1;
        end
        if (state == WDRS_RUN && tick && count[obit]) begin
            next_wdt_reset = 1'b1;
        end
    end

    // CPU switch seen at stop entry is not a new switch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_fast_seen <= 1'b0;
        end else if (state == WDRS_RUN) begin
            cpu_fast_seen <= env.cpu_fast;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg      <= `WDRS_MODE_RESET;
            mode_written  <= 1'b0;
            count         <= '0;
            state         <= WDRS_RUN;
            pending       <= 1'b0;
            was_stop      <= 1'b0;
            wdt_reset     <= 1'b0;
            slow_prev     <= 1'b0;
            fast_prev     <= 1'b0;
            aw_held       <= 1'b0;
            aw_addr       <= 4'h0;
            w_held        <= 1'b0;
            w_data        <= 32'h0;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `WDRS_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `WDRS_RESP_OKAY;
        end else begin
            mode_reg      <= next_mode_reg;
            mode_written  <= next_mode_written;
            count         <= next_count;
            state         <= next_state;
            pending       <= next_pending;
            was_stop      <= next_was_stop;
            wdt_reset     <= next_wdt_reset;
            slow_prev     <= env.slow_tick;
            fast_prev     <= env.fast_tick;
            aw_held       <= next_aw_held;
            aw_addr       <= next_aw_addr;
            w_held        <= next_w_held;
            w_data        <= next_w_data;
            w_strb        <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
    end
endmodule // wdrs_top

/* File: sim/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
    logic slow = 0, fast = 0, halt = 0, stop = 0, cpu_fast = 0, wdt_reset;
    logic settled = 1, fast_on = 1;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, seed = 32'h34;
    logic [1:0] bresp, rresp;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    bit rstq[$];
    int bad_count = 0, compares = 0, cyc = 0, c = 0;
    logic [7:0] v;

    always #10 aclk = ~aclk;
    always begin
        repeat (5) @(posedge aclk);
        if (fast_on) fast <= ~fast;
    end

    wdrs_top #(.STOPPABLE(1'b1), .CNT_W(21)) wdrs_top_inst (.aclk, .aresetn,
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .slow_tick_in(slow),
        .fast_tick_in(fast), .halt_in(halt), .stop_in(stop),
        .cpu_fast_in(cpu_fast), .settled_in(settled), .wdt_reset);

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Status word: count, state, mode-written flag, no pending reset
    function automatic logic [33:0] st(bit w, int n, logic [1:0] s);
        return {2'h0, 28'(n), s, w, 1'b0};
    endfunction

    task automatic chk(string n, logic [33:0] e, logic [33:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Result watcher: oldest expectation against each answer seen
    always @(posedge aclk) begin
        cyc++;
        if (cyc > 40000) begin
            bad_count++;
            print_verdict();
        end else begin
            if (rvalid && rready) chk("read", rq.pop_front(), {rresp, rdata});
            if (bvalid && bready) chk("bresp", 34'(bq.pop_front()),
                                      34'(bresp));
            if (wdt_reset) begin
                if (rstq.size() == 0) chk("unexpected wdt_reset", 34'h0,
                                          34'h1);
                else void'(rstq.pop_front());
            end
        end
    end

    task automatic wr(logic [3:0] a, logic [7:0] d, logic [3:0] s,
                      logic [1:0] e);
        bq.push_back(e);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, logic [33:0] e);
        rq.push_back(e);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
    endtask
    // Slow oscillator edges, each well apart for the synchroniser
    task automatic tk(int n);
        repeat (n) begin
            repeat (4) @(posedge aclk);
            slow <= 1'b1;
            repeat (4) @(posedge aclk);
            slow <= 1'b0;
        end
    endtask
    task automatic settle();
        repeat (8) @(posedge aclk);
        chk("missing wdt_reset", 34'h0, 34'(rstq.size()));
    endtask

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(4'h0, 34'h67);
        rd(4'h4, 34'h9A);
        rd(4'h8, st(0, 0, 2'h0));
        wr(4'h8, 8'h00, 4'h1, 2'h2);
        wr(4'hC, 8'h00, 4'h1, 2'h0);
        rd(4'hC, 34'h0);
        rd(4'h2, 34'h2_0000_0000);
        tk(3);
        wr(4'h4, 8'hAC, 4'h1, 2'h0);
        tk(2);
        rd(4'h8, st(0, 2, 2'h0));
        v = 8'(xs());
        if (v == 8'hAC) v = 8'h5C;
        rstq.push_back(1);
        wr(4'h4, v, 4'h1, 2'h0);
        rstq.push_back(1);
        wr(4'h4, 8'hAC, 4'h0, 2'h0);
        settle();
        wr(4'h0, 8'h60, 4'h1, 2'h0);
        rd(4'h0, 34'h60);
        rd(4'h8, st(1, 0, 2'h0));
        for (int m = 0; m < 2; m++) begin
            cpu_fast <= 1'(xs());
            tk(4);
            c += 4;
            if (m == 0) halt <= 1'b1;
            else stop <= 1'b1;
            repeat (8) @(posedge aclk);
            tk(3);
            rd(4'h8, st(1, c, 2'h1));
            halt <= 1'b0;
            stop <= 1'b0;
            repeat (8) @(posedge aclk);
            tk(2);
            c += 2;
            rd(4'h8, st(1, c, 2'h0));
        end
        tk(2048 - c);
        settle();
        rstq.push_back(1);
        tk(1);
        settle();
        rstq.push_back(1);
        wr(4'h0, 8'h67, 4'h1, 2'h0);
        settle();
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        wr(4'h0, 8'h70, 4'h1, 2'h0);
        wr(4'h4, v, 4'h1, 2'h0);
        wr(4'h4, 8'hAC, 4'h0, 2'h0);
        wr(4'h0, 8'h67, 4'h1, 2'h0);
        tk(3);
        rd(4'h0, 34'h70);
        rd(4'h8, st(1, 0, 2'h3));
        settle();
        // Fast source frozen so the held count stays known
        fast_on <= 1'b0;
        settled <= 1'b0;
        cpu_fast <= 1'b1;
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (8) @(posedge aclk);
        wr(4'h0, 8'h68, 4'h1, 2'h0);
        for (int m = 0; m < 2; m++) begin
            stop <= 1'b1;
            repeat (8) @(posedge aclk);
            stop <= 1'b0;
            repeat (8) @(posedge aclk);
            rd(4'h8, st(1, 0, 2'h2));
            if (m == 0) settled <= 1'b1;
            else cpu_fast <= 1'b1;
            repeat (8) @(posedge aclk);
            rd(4'h8, st(1, 0, 2'h0));
            settled <= 1'b0;
            cpu_fast <= 1'b0;
            repeat (8) @(posedge aclk);
        end
        print_verdict();
    end
endmodule // tb_top

/* File: sim/wdrs_top_assertions.sv */
`timescale 1ns/10ps
module wdrs_top_assertions #(
    parameter bit STOPPABLE = 1'b0,
    parameter int CNT_W     = 21
) (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Bus handshakes watched
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [3:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Reset request
    input wire logic        wdt_reset
);
    logic [3:0] rd_sel;
    logic [3:0] next_rd_sel;
    // Remembers which register the pending read targets
    always_comb next_rd_sel = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr
                                                               : rd_sel;
    always_ff @(posedge aclk) rd_sel <= !aresetn ? 4'h0 : next_rd_sel;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_read_of(logic [3:0] a);
        s_axi_rvalid && rd_sel == a;
    endsequence

    a_quiet_reset: assert property (disable iff (1'b0)
        !aresetn |=> !wdt_reset && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs busy out of reset");
    a_pulse_single: assert property (wdt_reset |=> !wdt_reset)
        else $error("reset request longer than one cycle");
    a_key_reads: assert property (s_read_of(4'h4) |->
        s_axi_rdata == 32'h0000009A) else $error("key read wrong");
    a_mode_top: assert property (s_read_of(4'h0) |->
        s_axi_rdata[7:5] == 3'h3) else $error("mode top bits wrong");
    a_mode_fixed: assert property (s_read_of(4'h0) |->
        STOPPABLE || s_axi_rdata[4:3] == 2'h0)
        else $error("clock select changed");
    a_never_halts: assert property (s_read_of(4'h8) |->
        STOPPABLE || s_axi_rdata[3:2] == 2'h0)
        else $error("fixed dog left run");
    a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready |->
        ##[1:4] s_axi_bvalid) else $error("write answer late");
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
endmodule // wdrs_top_assertions

bind wdrs_top wdrs_top_assertions #(.STOPPABLE(STOPPABLE), .CNT_W(CNT_W))
    wdrs_top_assertions_inst (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .wdt_reset);
